// ==== rtl/shrt_pkg.sv ====
// Constants shared by the system hang reset timer
package shrt_pkg;

   // Configuration port addresses
   localparam logic [7:0] PORT_INDEX       = 8'h2E;
   localparam logic [7:0] PORT_DATA        = 8'h2F;

   // Access keys written to the index port
   localparam logic [7:0] KEY_UNLOCK       = 8'h87;
   localparam logic [7:0] KEY_LOCK         = 8'hAA;

   // Register indexes
   localparam logic [7:0] IDX_LDEV_SELECT  = 8'h07;
   localparam logic [7:0] IDX_ACTIVATE     = 8'h30;
   localparam logic [7:0] IDX_UNIT_SELECT  = 8'hF0;
   localparam logic [7:0] IDX_TIMEOUT      = 8'hF1;

   // Logical device number of the timer
   localparam logic [7:0] LDEV_TIMER       = 8'h08;

   // Field values
   localparam logic [7:0] ACTIVATE_ON      = 8'h01;
   localparam logic [7:0] ACTIVATE_OFF     = 8'h00;
   localparam logic [7:0] UNIT_SECONDS     = 8'h00;
   localparam logic [7:0] UNIT_MINUTES     = 8'h08;
   localparam int         ACTIVATE_BIT     = 0;

   // Reset values, and values read back when locked or unmapped
   localparam logic [7:0] RST_INDEX        = 8'h00;
   localparam logic [7:0] RST_LDEV         = 8'h00;
   localparam logic [7:0] RST_ACTIVATE     = 8'h00;
   localparam logic [7:0] RST_UNIT         = 8'h00;
   localparam logic [7:0] RST_TIMEOUT      = 8'h00;
   localparam logic [7:0] READ_LOCKED      = 8'hFF;
   localparam logic [7:0] READ_UNMAPPED    = 8'h00;

   // Time base
   localparam int unsigned CLK_PERIOD_NS      = 40;
   localparam int unsigned ONE_SECOND_NS      = 1_000_000_000;
   localparam int unsigned CYCLES_PER_SECOND  = ONE_SECOND_NS / CLK_PERIOD_NS;
   localparam int unsigned SECONDS_PER_MINUTE = 60;

   // Unlock sequence states
   typedef enum logic [2:0] {
      ACC_LOCKED = 3'b001,
      ACC_KEY1   = 3'b010,
      ACC_OPEN   = 3'b100
   } shrt_access_type;

endpackage : shrt_pkg

// ==== rtl/shrt_top.sv ====
// System hang reset timer: index/data configuration port and countdown logic
`timescale 1ns/1ns

// Function
// RULE_01: Count down, request reset at zero.
// RULE_02: Host loads and reloads count before expiry.
// RULE_03: Two 87 writes to 2E unlock.
// RULE_04: Index F0 selects seconds or minutes.
// RULE_05: Index F1 holds timeout count.
// RULE_06: Device 08, register 30 activates timer.
module shrt_top #(
   parameter int unsigned CYCLES_PER_SECOND = shrt_pkg::CYCLES_PER_SECOND
) (
   input  wire logic       i_clk,
   input  wire logic       i_arst_n,
   input  wire logic       i_io_wr,
   input  wire logic       i_io_rd,
   input  wire logic [7:0] i_io_addr,
   input  wire logic [7:0] i_io_wdata,
   output logic      [7:0] o_io_rdata,
   output logic            o_sys_reset_req,
   output logic            o_timer_active
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release

   logic rst_meta;
   logic rst_n;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration access

   shrt_pkg::shrt_access_type access;
   shrt_pkg::shrt_access_type next_access;
   logic [7:0]                index;
   logic [7:0]                next_index;
   logic [7:0]                ldev;
   logic [7:0]                next_ldev;
   logic [7:0]                activate;
   logic [7:0]                next_activate;
   logic [7:0]                unit;
   logic [7:0]                next_unit;
   logic [7:0]                rdata;
   logic [7:0]                next_rdata;
   logic [7:0]                count;

   logic wr_index;
   logic wr_data;
   logic timer_sel;
   logic load_timeout;
   logic write_activate;

   assign wr_index       = i_io_wr && (i_io_addr == shrt_pkg::PORT_INDEX);
   // Data writes count only once the key sequence has opened the port
   assign wr_data        = i_io_wr && (i_io_addr == shrt_pkg::PORT_DATA)
                           && (access == shrt_pkg::ACC_OPEN); // RULE_03
   assign timer_sel      = (ldev == shrt_pkg::LDEV_TIMER); // RULE_06
   assign load_timeout   = wr_data && timer_sel && (index == shrt_pkg::IDX_TIMEOUT); // RULE_05
   assign write_activate = wr_data && timer_sel && (index == shrt_pkg::IDX_ACTIVATE); // RULE_06

   always_comb begin
      next_access   = access;
      next_index    = index;
      next_ldev     = ldev;
      next_activate = activate;
      next_unit     = unit;
      next_rdata    = rdata;
      unique case (access)
         shrt_pkg::ACC_LOCKED: begin
            if (wr_index && i_io_wdata == shrt_pkg::KEY_UNLOCK) begin
               next_access = shrt_pkg::ACC_KEY1; // RULE_03
            end
         end
         shrt_pkg::ACC_KEY1: begin
            // Any other index write breaks the pair, so a stray 87 cannot unlock
            if (wr_index) begin
               next_access = (i_io_wdata == shrt_pkg::KEY_UNLOCK) ?
                             shrt_pkg::ACC_OPEN : shrt_pkg::ACC_LOCKED; // RULE_03
            end
         end
         shrt_pkg::ACC_OPEN: begin
            if (wr_index) begin
               if (i_io_wdata == shrt_pkg::KEY_LOCK) begin
                  next_access = shrt_pkg::ACC_LOCKED;
               end else begin
                  next_index = i_io_wdata;
               end
            end
         end
      endcase
      if (wr_data) begin
         if (index == shrt_pkg::IDX_LDEV_SELECT) begin
            next_ldev = i_io_wdata; // RULE_06
         end else if (timer_sel && index == shrt_pkg::IDX_ACTIVATE) begin
            next_activate = i_io_wdata; // RULE_06
         end else if (timer_sel && index == shrt_pkg::IDX_UNIT_SELECT) begin
            next_unit = i_io_wdata; // RULE_04
         end
      end
      if (i_io_rd) begin
         if (access != shrt_pkg::ACC_OPEN) begin
            next_rdata = shrt_pkg::READ_LOCKED;
         end else if (i_io_addr == shrt_pkg::PORT_INDEX) begin
            next_rdata = index;
         end else if (i_io_addr != shrt_pkg::PORT_DATA) begin
            next_rdata = shrt_pkg::READ_UNMAPPED;
         end else if (index == shrt_pkg::IDX_LDEV_SELECT) begin
            next_rdata = ldev;
         end else if (timer_sel && index == shrt_pkg::IDX_ACTIVATE) begin
            next_rdata = activate;
         end else if (timer_sel && index == shrt_pkg::IDX_UNIT_SELECT) begin
            next_rdata = unit;
         end else if (timer_sel && index == shrt_pkg::IDX_TIMEOUT) begin
            // Live remaining count, so software can watch the countdown
            next_rdata = count;
         end else begin
            next_rdata = shrt_pkg::READ_UNMAPPED;
         end
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         access   <= shrt_pkg::ACC_LOCKED;
         index    <= shrt_pkg::RST_INDEX;
         ldev     <= shrt_pkg::RST_LDEV;
         activate <= shrt_pkg::RST_ACTIVATE;
         unit     <= shrt_pkg::RST_UNIT;
         rdata    <= shrt_pkg::RST_INDEX;
      end else begin
         access   <= next_access;
         index    <= next_index;
         ldev     <= next_ldev;
         activate <= next_activate;
         unit     <= next_unit;
         rdata    <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Countdown

   logic [31:0] sec_cnt;
   logic [31:0] next_sec_cnt;
   logic [5:0]  min_cnt;
   logic [5:0]  next_min_cnt;
   logic [7:0]  next_count;
   logic        expired;
   logic        next_expired;
   logic        running;
   logic        next_running;

   logic sec_tick;
   logic min_wrap;
   logic unit_tick;
   logic counting;

   assign sec_tick  = (sec_cnt == CYCLES_PER_SECOND - 32'd1);
   assign min_wrap  = (min_cnt == 6'(shrt_pkg::SECONDS_PER_MINUTE - 1));
   // Any unit value other than minutes counts in seconds
   assign unit_tick = sec_tick && ((unit != shrt_pkg::UNIT_MINUTES) || min_wrap); // RULE_04
   assign counting  = activate[shrt_pkg::ACTIVATE_BIT] && (count != 8'h00); // RULE_06

   always_comb begin
      next_sec_cnt = sec_cnt;
      next_min_cnt = min_cnt;
      next_count   = count;
      next_expired = expired;
      // Reload restarts the prescalers, so the first period after it is a full unit long
      if (load_timeout) begin
         next_count   = i_io_wdata; // RULE_05
         next_sec_cnt = 32'h0000_0000;
         next_min_cnt = 6'h00;
         next_expired = 1'b0;
      end else if (write_activate) begin
         next_sec_cnt = 32'h0000_0000;
         next_min_cnt = 6'h00;
         next_expired = 1'b0; // RULE_06
      end else if (counting) begin
         next_sec_cnt = sec_tick ? 32'h0000_0000 : sec_cnt + 32'd1;
         if (sec_tick) begin
            next_min_cnt = min_wrap ? 6'h00 : min_cnt + 6'd1;
         end
         if (unit_tick) begin
            next_count = count - 8'd1; // RULE_01
            if (count == 8'h01) begin
               next_expired = 1'b1; // RULE_01
            end
         end
      end
      next_running = counting && !load_timeout;
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         sec_cnt <= 32'h0000_0000;
         min_cnt <= 6'h00;
         count   <= shrt_pkg::RST_TIMEOUT;
         expired <= 1'b0;
         running <= 1'b0;
      end else begin
         sec_cnt <= next_sec_cnt;
         min_cnt <= next_min_cnt;
         count   <= next_count;
         expired <= next_expired;
         running <= next_running;
      end
   end

   // Request stays high until reloaded, register 30 is written, or the chip reset clears it
   assign o_sys_reset_req = expired; // RULE_01
   assign o_timer_active  = running;
   assign o_io_rdata      = rdata;

endmodule : shrt_top

// ==== tb/shrt_monitor.sv ====
// Port checker of the system hang reset timer
`timescale 1ns/1ns
////////////////////////////////////////
module shrt_monitor (
   input wire logic       i_clk,
   input wire logic       i_arst_n,
   input wire logic       i_io_wr,
   input wire logic       i_io_rd,
   input wire logic [7:0] o_io_rdata,
   input wire logic       o_sys_reset_req,
   input wire logic       o_timer_active
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);

   property p_rdata_hold;
      !i_io_rd |=> $stable(o_io_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data changed without a read");
   property p_req_rise;
      $rose(o_sys_reset_req) |-> $past(o_timer_active);
   endproperty
   a_req_rise: assert property (p_req_rise)
      else $error("reset request without a running count");
   property p_req_fall;
      $fell(o_sys_reset_req) |-> $past(i_io_wr);
   endproperty
   a_req_fall: assert property (p_req_fall)
      else $error("reset request dropped without a write");
   // Activation lags the write by two register stages
   property p_act_rise;
      $rose(o_timer_active) |-> $past(i_io_wr) || $past(i_io_wr, 2);
   endproperty
   a_act_rise: assert property (p_act_rise)
      else $error("timer started without a write");
   property p_expired_idle;
      o_sys_reset_req && $past(o_sys_reset_req) |-> !o_timer_active;
   endproperty
   a_expired_idle: assert property (p_expired_idle)
      else $error("timer still counting after expiry");
   c_expire: cover property ($rose(o_sys_reset_req));
   c_start: cover property ($rose(o_timer_active));
   c_read: cover property (i_io_rd ##1 !i_io_rd);
endmodule : shrt_monitor

bind shrt_top shrt_monitor shrt_monitor_inst (
   .i_clk          (i_clk),
   .i_arst_n       (i_arst_n),
   .i_io_wr        (i_io_wr),
   .i_io_rd        (i_io_rd),
   .o_io_rdata     (o_io_rdata),
   .o_sys_reset_req(o_sys_reset_req),
   .o_timer_active (o_timer_active)
);

// ==== tb/shrt_host.sv ====
// Host software model driving the index and data ports
`timescale 1ns/1ns
////////////////////////////////////////
module shrt_host (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_io_rdata,
   output logic            o_io_wr,
   output logic            o_io_rd,
   output logic      [7:0] o_io_addr,
   output logic      [7:0] o_io_wdata
);
   initial begin
      o_io_wr = 1'b0;
      o_io_rd = 1'b0;
      o_io_addr = 8'h00;
      o_io_wdata = 8'h00;
   end
   // Released bus shows an unmapped address and flipped data
   task automatic put(input logic [7:0] a, input logic [7:0] d, input logic r);
      @(posedge i_clk);
      o_io_wr <= ~r;
      o_io_rd <= r;
      o_io_addr <= a;
      o_io_wdata <= d;
      @(posedge i_clk);
      o_io_wr <= 1'b0;
      o_io_rd <= 1'b0;
      o_io_addr <= 8'h00;
      o_io_wdata <= ~d;
   endtask : put
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      put(a, d, 1'b0);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      put(a, 8'h00, 1'b1);
      @(negedge i_clk);
      d = i_io_rdata;
   endtask : rd
   task automatic cfg(input logic [7:0] idx, input logic [7:0] v);
      wr(8'h2E, idx);
      wr(8'h2F, v);
   endtask : cfg
   task automatic unlock;
      wr(8'h2E, 8'h87);
      wr(8'h2E, 8'h87);
   endtask : unlock
endmodule : shrt_host

// ==== tb/system_hang_reset_timer_test.sv ====
// Self-checking bench of the system hang reset timer
`timescale 1ns/1ns
////////////////////////////////////////
module system_hang_reset_timer_test;
   localparam int CPS = 4;
   logic       clk = 1'b0;
   logic       arst_n = 1'b0;
   logic       wr, rd, req, act;
   logic [7:0] addr, wdata, rdata, d;
   int         failures = 0;
   int         checks = 0;
   int         n;

   always #20 clk = ~clk;
   shrt_top #(.CYCLES_PER_SECOND(CPS)) shrt_top_inst (.i_clk(clk), .i_arst_n(arst_n),
      .i_io_wr(wr), .i_io_rd(rd), .i_io_addr(addr), .i_io_wdata(wdata), .o_io_rdata(rdata),
      .o_sys_reset_req(req), .o_timer_active(act));
   shrt_host shrt_host_inst (.i_clk(clk), .i_io_rdata(rdata), .o_io_wr(wr), .o_io_rd(rd),
      .o_io_addr(addr), .o_io_wdata(wdata));

   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Counts falling edges until the request shows, bounded
   task automatic wait_req(input int lim);
      n = 0;
      while (req !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask : wait_req
   task automatic print_verdict;
      if (failures == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////
   task automatic t_lock;
      shrt_host_inst.rd(8'h2F, d);
      chk(d, 8'hFF);
      shrt_host_inst.wr(8'h2E, 8'h87);
      shrt_host_inst.wr(8'h2E, 8'h07);
      shrt_host_inst.wr(8'h2E, 8'h87);
      shrt_host_inst.rd(8'h2F, d);
      chk(d, 8'hFF);
      shrt_host_inst.unlock();
   endtask : t_lock
   task automatic t_regs;
      shrt_host_inst.cfg(8'h07, 8'h00);
      shrt_host_inst.cfg(8'hF0, 8'h08);
      shrt_host_inst.rd(8'h2F, d);
      chk(d, 8'h00);
      shrt_host_inst.cfg(8'h07, 8'h08);
      shrt_host_inst.rd(8'h2F, d);
      chk(d, 8'h08);
      // A unit write made while another device was selected must not have landed
      shrt_host_inst.wr(8'h2E, 8'hF0);
      shrt_host_inst.rd(8'h2F, d);
      chk(d, 8'h00);
      shrt_host_inst.wr(8'h2F, 8'h08);
      shrt_host_inst.rd(8'h2F, d);
      chk(d, 8'h08);
      shrt_host_inst.rd(8'h80, d);
      chk(d, 8'h00);
   endtask : t_regs
   task automatic t_sec;
      shrt_host_inst.cfg(8'h30, 8'h01);
      shrt_host_inst.cfg(8'hF0, 8'h00);
      shrt_host_inst.cfg(8'hF1, 8'h02);
      wait_req(40);
      chk(9'(n), 9'(2 * CPS + 1));
      shrt_host_inst.rd(8'h2F, d);
      chk(d, 8'h00);
      chk(act, 1'b0);
      repeat (5) shrt_host_inst.wr(8'h2F, 8'h02);
      // Reloads faster than one unit keep the count from moving
      shrt_host_inst.rd(8'h2F, d);
      chk(d, 8'h02);
      chk(req, 1'b0);
   endtask : t_sec
   task automatic t_min;
      shrt_host_inst.cfg(8'hF0, 8'h08);
      shrt_host_inst.cfg(8'hF1, 8'h01);
      wait_req(400);
      chk(9'(n), 9'(60 * CPS + 1));
      // Active flag lags the count by one cycle, so it still shows here
      chk(act, 1'b1);
   endtask : t_min
   task automatic t_off;
      shrt_host_inst.cfg(8'hF0, 8'h00);
      shrt_host_inst.cfg(8'h30, 8'h00);
      shrt_host_inst.cfg(8'hF1, 8'h01);
      repeat (20) @(negedge clk);
      chk({req, act}, 2'b00);
      shrt_host_inst.rd(8'h2F, d);
      chk(d, 8'h01);
      shrt_host_inst.cfg(8'h30, 8'h01);
      wait_req(40);
      chk(9'(n), 9'(CPS + 1));
      shrt_host_inst.wr(8'h2E, 8'hAA);
      shrt_host_inst.rd(8'h2F, d);
      chk(d, 8'hFF);
   endtask : t_off
   task automatic t_rst;
      // Reset after expiry: outputs drop at once and the port locks again
      @(posedge clk);
      arst_n <= 1'b0;
      @(negedge clk);
      chk(rdata, 8'h00);
      chk({req, act}, 2'b00);
      @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      shrt_host_inst.rd(8'h2F, d);
      chk(d, 8'hFF);
   endtask : t_rst
   ////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_lock();
      t_regs();
      t_sec();
      t_min();
      t_off();
      t_rst();
      print_verdict();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      repeat (3000) @(posedge clk);
      failures++;
      print_verdict();
   end
endmodule : system_hang_reset_timer_test
